// *** hw/general_purpose_timer_unit.sv ***
// Purpose: Two-group 16-bit general purpose timer unit with AXI4-Lite registers
// Assumes: Pins are asynchronous and pass two flip-flops before use
// Notes:   Software value writes win over any hardware update in that cycle
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps

// What this block does
// - Five independent 16-bit timers, two groups, chainable within a group.
// - Group one timers select timer, gated, counter or incremental mode.
// - Timer mode counts prescaled clock; counter mode counts input pin edges.
// - Gated mode counts prescaled clock only while the gate level allows.
// - One input pin per group one timer, used as gate or count clock.
// - Group one finest count period is sixteen half clock periods.
// - Software up/down direction, optionally flipped by direction pin level.
// - Incremental mode derives count and direction from quadrature inputs.
// - Core one toggle latch flips on wrap and may drive an output pin.
// - Core one toggle latch can clock either auxiliary timer.
// - Auxiliary timer stops while used as capture or reload register.
// - Capture copies core one value into auxiliary timer on pin edge.
// - Reload loads core one from auxiliary timer on pin or latch edge.
// - Both auxiliaries reload core one on opposite latch edges for PWM.
// - Group two finest period eight half clocks, prescaled, programmable direction.
// - Core two toggle latch flips on wrap and can clock aux timer c.
// - Optionally core two reloads from capture register on each wrap.
// - Capture pin edge latches aux c value; aux c optionally clears.
// - Capture trigger may instead come from core one input or direction pin.
module general_purpose_timer_unit
  import gpt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  timerInputPin,
  input  wire logic [2:0]  directionInputPin,
  input  wire logic        captureInputPin,
  output var  logic        toggleOutputPin,
  output var  logic [5:0]  requestFlags
);

  // Pin synchronisers: stage A feeds only stage B
  logic [6:0]  syncA;
  logic [6:0]  syncB;
  logic [6:0]  syncC;
  logic [6:0]  pinRise;
  logic [6:0]  pinFall;
  logic [15:0] preCnt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= {captureInputPin, directionInputPin, timerInputPin};
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  assign pinRise = syncB & ~syncC;
  assign pinFall = ~syncB & syncC;

  // Free-running prescaler shared by both groups
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preCnt <= '0;
    end else begin
      preCnt <= preCnt + 16'h0001;
    end
  end

  // One-cycle tick every base*2^sel cycles
  function automatic logic tickAt(input logic [15:0] cnt, input logic [15:0] base,
                                  input logic [2:0] sel);
    logic [15:0] mask;
    mask = (base << sel) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction : tickAt

  // AXI4-Lite write path
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        regWe;
  logic        wrOk;

  assign regWe = awHeld & wHeld & ~s_axi_bvalid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeld        <= 1'b0;
      s_axi_awready <= 1'b0;
      awAddrQ       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld        <= 1'b1;
      s_axi_awready <= 1'b0;
      awAddrQ       <= s_axi_awaddr;
    end else if (regWe) begin
      awHeld <= 1'b0;
    end else if (!awHeld) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wHeld        <= 1'b0;
      s_axi_wready <= 1'b0;
      wDataQ       <= '0;
      wStrbQ       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld        <= 1'b1;
      s_axi_wready <= 1'b0;
      wDataQ       <= s_axi_wdata;
      wStrbQ       <= s_axi_wstrb;
    end else if (regWe) begin
      wHeld <= 1'b0;
    end else if (!wHeld) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (awAddrQ)
      ADDR_CTRL_AUX_A, ADDR_CTRL_CORE_ONE, ADDR_CTRL_AUX_B, ADDR_CTRL_AUX_C,
      ADDR_CTRL_CORE_TWO, ADDR_CTRL_CAPTURE, ADDR_VAL_AUX_A, ADDR_VAL_CORE_ONE,
      ADDR_VAL_AUX_B, ADDR_VAL_AUX_C, ADDR_VAL_CORE_TWO, ADDR_VAL_CAPTURE,
      ADDR_STATUS, ADDR_PINS: wrOk = 1'b1;
      default:                wrOk = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (regWe) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction : merge

  // Control registers
  g1_ctrl_t  g1Ctrl [0:2];
  g2_ctrl_t  auxCCtrl;
  g2_ctrl_t  core2Ctrl;
  cap_ctrl_t capCtrl;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        g1Ctrl[k] <= g1_ctrl_t'(CTRL_RESET);
      end
      auxCCtrl  <= g2_ctrl_t'(CTRL_RESET);
      core2Ctrl <= g2_ctrl_t'(CTRL_RESET);
      capCtrl   <= cap_ctrl_t'(CTRL_RESET);
    end else if (regWe) begin
      for (int k = 0; k < 3; k++) begin
        if (awAddrQ == G1_CTRL_ADDR[k]) begin
          g1Ctrl[k] <= g1_ctrl_t'(merge(g1Ctrl[k], wDataQ, wStrbQ));
        end
      end
      if (awAddrQ == ADDR_CTRL_AUX_C) begin
        auxCCtrl <= g2_ctrl_t'(merge(auxCCtrl, wDataQ, wStrbQ));
      end
      if (awAddrQ == ADDR_CTRL_CORE_TWO) begin
        core2Ctrl <= g2_ctrl_t'(merge(core2Ctrl, wDataQ, wStrbQ));
      end
      if (awAddrQ == ADDR_CTRL_CAPTURE) begin
        capCtrl <= cap_ctrl_t'(merge(capCtrl, wDataQ, wStrbQ));
      end
    end
  end

  // Group one
  logic [15:0] g1Val [0:2];
  logic [2:0]  g1Cnt;
  logic [2:0]  g1Down;
  logic [2:0]  g1Wrap;
  logic [2:0]  g1Cap;
  logic        core1Latch;
  logic        latchRise;
  logic        latchFall;
  logic        reloadA;
  logic        reloadB;

  // Latch edge known in the wrap cycle, so a reload lands without a lost count
  assign latchRise = g1Wrap[CORE1_IDX] & ~core1Latch;
  assign latchFall = g1Wrap[CORE1_IDX] & core1Latch;

  // Aux trigger: sel[2] picks latch edges over own pin edges
  function automatic logic auxTrig(input g1_ctrl_t c, input logic pr, input logic pf,
                                   input logic lr, input logic lf);
    return c.sel[2] ? edgeHit(c.sel[1:0], lr, lf) : edgeHit(c.sel[1:0], pr, pf);
  endfunction : auxTrig

  assign reloadA = (g1Ctrl[0].mode == MODE_RELOAD) &&
                   auxTrig(g1Ctrl[0], pinRise[0], pinFall[0], latchRise, latchFall);
  assign reloadB = (g1Ctrl[2].mode == MODE_RELOAD) &&
                   auxTrig(g1Ctrl[2], pinRise[2], pinFall[2], latchRise, latchFall);

  for (genvar i = 0; i < 3; i++) begin : g_grp1
    logic tick;
    logic cntEv;
    logic aEdge;
    logic bEdge;
    logic quadDown;

    always_comb begin
      tick     = tickAt(preCnt, G1_BASE_CYCLES, g1Ctrl[i].sel);
      aEdge    = pinRise[i] | pinFall[i];
      bEdge    = pinRise[3+i] | pinFall[3+i];
      // A change with A==B after it means B leads: count down
      quadDown = aEdge ? (syncB[i] == syncB[3+i]) : (syncB[i] != syncB[3+i]);
      case (g1Ctrl[i].mode)
        MODE_TIMER:       cntEv = tick;
        MODE_GATE_LOW:    cntEv = tick & ~syncB[i];
        MODE_GATE_HIGH:   cntEv = tick & syncB[i];
        MODE_COUNTER:     cntEv = (i != CORE1_IDX)
                                ? auxTrig(g1Ctrl[i], pinRise[i], pinFall[i], latchRise, latchFall)
                                : edgeHit(g1Ctrl[i].sel[1:0], pinRise[i], pinFall[i]);
        MODE_INCREMENTAL: cntEv = (g1Ctrl[i].sel[0] & aEdge) | (g1Ctrl[i].sel[1] & bEdge);
        default:          cntEv = 1'b0;
      endcase
    end

    assign g1Cnt[i]  = g1Ctrl[i].run & cntEv;
    assign g1Down[i] = (g1Ctrl[i].mode == MODE_INCREMENTAL) ? quadDown
                     : g1Ctrl[i].down ^ (g1Ctrl[i].extDir & syncB[3+i]);
    assign g1Wrap[i] = g1Cnt[i] & (g1Down[i] ? (g1Val[i] == TIMER_MIN)
                                             : (g1Val[i] == TIMER_MAX));
    assign g1Cap[i]  = (i != CORE1_IDX) && (g1Ctrl[i].mode == MODE_CAPTURE) &&
                       edgeHit(g1Ctrl[i].sel[1:0], pinRise[i], pinFall[i]);

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        g1Val[i] <= VAL_RESET;
      end else if (regWe && awAddrQ == G1_VAL_ADDR[i]) begin
        g1Val[i] <= merge(g1Val[i], wDataQ, wStrbQ);
      end else if (i == CORE1_IDX && (reloadA || reloadB)) begin
        // Aux a wins if both fire on the same edge
        g1Val[i] <= reloadA ? g1Val[0] : g1Val[2];
      end else if (g1Cap[i]) begin
        g1Val[i] <= g1Val[CORE1_IDX];
      end else if (g1Cnt[i]) begin
        g1Val[i] <= g1Down[i] ? g1Val[i] - 16'h0001 : g1Val[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core1Latch <= 1'b0;
    end else if (g1Wrap[CORE1_IDX]) begin
      core1Latch <= ~core1Latch;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      toggleOutputPin <= 1'b0;
    end else begin
      toggleOutputPin <= g1Ctrl[CORE1_IDX].outEn & core1Latch;
    end
  end

  // Group two
  logic [15:0] auxCVal;
  logic [15:0] core2Val;
  logic [15:0] capVal;
  logic        core2Latch;
  logic        core2Cnt;
  logic        core2Wrap;
  logic        auxCCnt;
  logic        auxCWrap;
  logic        srcRise;
  logic        srcFall;
  logic        capEvt;

  assign core2Cnt  = core2Ctrl.run & tickAt(preCnt, G2_BASE_CYCLES, core2Ctrl.sel);
  assign core2Wrap = core2Cnt & (core2Ctrl.down ? (core2Val == TIMER_MIN)
                                                : (core2Val == TIMER_MAX));
  assign auxCCnt   = auxCCtrl.run & (auxCCtrl.latchClk
                   ? edgeHit(auxCCtrl.sel[1:0], core2Wrap & ~core2Latch, core2Wrap & core2Latch)
                   : tickAt(preCnt, G2_BASE_CYCLES, auxCCtrl.sel));
  assign auxCWrap  = auxCCnt & (auxCCtrl.down ? (auxCVal == TIMER_MIN)
                                              : (auxCVal == TIMER_MAX));

  always_comb begin
    unique case (capCtrl.source)
      CAP_SRC_PIN: begin
        srcRise = pinRise[6];
        srcFall = pinFall[6];
      end
      CAP_SRC_CORE_IN: begin
        srcRise = pinRise[CORE1_IDX];
        srcFall = pinFall[CORE1_IDX];
      end
      CAP_SRC_CORE_DIR: begin
        srcRise = pinRise[3+CORE1_IDX];
        srcFall = pinFall[3+CORE1_IDX];
      end
      CAP_SRC_CORE_ANY: begin
        srcRise = pinRise[CORE1_IDX] | pinRise[3+CORE1_IDX];
        srcFall = pinFall[CORE1_IDX] | pinFall[3+CORE1_IDX];
      end
    endcase
  end

  assign capEvt = capCtrl.enable & edgeHit(capCtrl.edgeSel, srcRise, srcFall);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core2Val <= VAL_RESET;
    end else if (regWe && awAddrQ == ADDR_VAL_CORE_TWO) begin
      core2Val <= merge(core2Val, wDataQ, wStrbQ);
    end else if (core2Wrap && core2Ctrl.reloadEn) begin
      core2Val <= capVal;
    end else if (core2Cnt) begin
      core2Val <= core2Ctrl.down ? core2Val - 16'h0001 : core2Val + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core2Latch <= 1'b0;
    end else if (core2Wrap) begin
      core2Latch <= ~core2Latch;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      auxCVal <= VAL_RESET;
    end else if (regWe && awAddrQ == ADDR_VAL_AUX_C) begin
      auxCVal <= merge(auxCVal, wDataQ, wStrbQ);
    end else if (capEvt && capCtrl.clearAux) begin
      auxCVal <= VAL_RESET;
    end else if (auxCCnt) begin
      auxCVal <= auxCCtrl.down ? auxCVal - 16'h0001 : auxCVal + 16'h0001;
    end
  end

  // Capture takes the pre-clear value of aux c
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      capVal <= VAL_RESET;
    end else if (regWe && awAddrQ == ADDR_VAL_CAPTURE) begin
      capVal <= merge(capVal, wDataQ, wStrbQ);
    end else if (capEvt) begin
      capVal <= auxCVal;
    end
  end

  // Request flags, write one to clear; a new event beats the clear
  logic [5:0] flagSet;
  logic [5:0] flagClr;

  assign flagSet = {capEvt, core2Wrap, auxCWrap, g1Wrap};
  assign flagClr = (regWe && awAddrQ == ADDR_STATUS && wStrbQ[0]) ? wDataQ[5:0] : 6'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      requestFlags <= '0;
    end else begin
      requestFlags <= (requestFlags & ~flagClr) | flagSet;
    end
  end

  // AXI4-Lite read path
  logic [31:0] rdData;
  logic        rdOk;

  always_comb begin
    rdData = 32'h0000_0000;
    rdOk   = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL_AUX_A:    rdData = {16'h0000, g1Ctrl[0]};
      ADDR_CTRL_CORE_ONE: rdData = {16'h0000, g1Ctrl[1]};
      ADDR_CTRL_AUX_B:    rdData = {16'h0000, g1Ctrl[2]};
      ADDR_CTRL_AUX_C:    rdData = {16'h0000, auxCCtrl};
      ADDR_CTRL_CORE_TWO: rdData = {16'h0000, core2Ctrl};
      ADDR_CTRL_CAPTURE:  rdData = {16'h0000, capCtrl};
      ADDR_VAL_AUX_A:     rdData = {16'h0000, g1Val[0]};
      ADDR_VAL_CORE_ONE:  rdData = {16'h0000, g1Val[1]};
      ADDR_VAL_AUX_B:     rdData = {16'h0000, g1Val[2]};
      ADDR_VAL_AUX_C:     rdData = {16'h0000, auxCVal};
      ADDR_VAL_CORE_TWO:  rdData = {16'h0000, core2Val};
      ADDR_VAL_CAPTURE:   rdData = {16'h0000, capVal};
      ADDR_STATUS:        rdData = {22'h000000, core2Latch, core1Latch, 2'h0, requestFlags};
      ADDR_PINS:          rdData = {25'h0000000, syncB};
      default:            rdOk   = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rdData;
      s_axi_rresp   <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : general_purpose_timer_unit

// *** hw/gpt_pkg.sv ***
// Purpose: Shared constants and types for the general purpose timer unit
// Assumes: 100 MHz sys_clk, AXI4-Lite register access, 16-bit timers
// Notes:   Byte offsets are word aligned; timer data sits in bits 15:0

package gpt_pkg;

  // Timing
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int HALF_CLOCK_PS  = 5000;
  localparam int G1_RES_HALF    = 16;
  localparam int G2_RES_HALF    = 8;
  localparam logic [15:0] G1_BASE_CYCLES =
    16'((G1_RES_HALF * HALF_CLOCK_PS) / CLK_PERIOD_PS);
  localparam logic [15:0] G2_BASE_CYCLES =
    16'((G2_RES_HALF * HALF_CLOCK_PS) / CLK_PERIOD_PS);

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL_AUX_A    = 8'h00;
  localparam logic [7:0] ADDR_CTRL_CORE_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_AUX_B    = 8'h08;
  localparam logic [7:0] ADDR_CTRL_AUX_C    = 8'h0c;
  localparam logic [7:0] ADDR_CTRL_CORE_TWO = 8'h10;
  localparam logic [7:0] ADDR_CTRL_CAPTURE  = 8'h14;
  localparam logic [7:0] ADDR_VAL_AUX_A     = 8'h18;
  localparam logic [7:0] ADDR_VAL_CORE_ONE  = 8'h1c;
  localparam logic [7:0] ADDR_VAL_AUX_B     = 8'h20;
  localparam logic [7:0] ADDR_VAL_AUX_C     = 8'h24;
  localparam logic [7:0] ADDR_VAL_CORE_TWO  = 8'h28;
  localparam logic [7:0] ADDR_VAL_CAPTURE   = 8'h2c;
  localparam logic [7:0] ADDR_STATUS        = 8'h30;
  localparam logic [7:0] ADDR_PINS          = 8'h34;

  localparam logic [7:0] G1_CTRL_ADDR [0:2] =
    '{ADDR_CTRL_AUX_A, ADDR_CTRL_CORE_ONE, ADDR_CTRL_AUX_B};
  localparam logic [7:0] G1_VAL_ADDR [0:2] =
    '{ADDR_VAL_AUX_A, ADDR_VAL_CORE_ONE, ADDR_VAL_AUX_B};

  // Reset values and limits
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET  = 16'h0000;
  localparam logic [15:0] TIMER_MAX  = 16'hffff;
  localparam logic [15:0] TIMER_MIN  = 16'h0000;
  localparam int          CORE1_IDX  = 1;

  // Group one modes
  localparam logic [2:0] MODE_TIMER       = 3'h0;
  localparam logic [2:0] MODE_COUNTER     = 3'h1;
  localparam logic [2:0] MODE_GATE_LOW    = 3'h2;
  localparam logic [2:0] MODE_GATE_HIGH   = 3'h3;
  localparam logic [2:0] MODE_RELOAD      = 3'h4;
  localparam logic [2:0] MODE_CAPTURE     = 3'h5;
  localparam logic [2:0] MODE_INCREMENTAL = 3'h6;

  // Capture trigger sources
  localparam logic [1:0] CAP_SRC_PIN      = 2'h0;
  localparam logic [1:0] CAP_SRC_CORE_IN  = 2'h1;
  localparam logic [1:0] CAP_SRC_CORE_DIR = 2'h2;
  localparam logic [1:0] CAP_SRC_CORE_ANY = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [5:0] spare;
    logic       outEn;
    logic       extDir;
    logic       down;
    logic       run;
    logic [2:0] mode;
    logic [2:0] sel;
  } g1_ctrl_t;

  typedef struct packed {
    logic [4:0] spare;
    logic       reloadEn;
    logic [1:0] spareB;
    logic       down;
    logic       run;
    logic [1:0] spareC;
    logic       latchClk;
    logic [2:0] sel;
  } g2_ctrl_t;

  typedef struct packed {
    logic [9:0] spare;
    logic       enable;
    logic       clearAux;
    logic [1:0] source;
    logic [1:0] edgeSel;
  } cap_ctrl_t;

  // Edge selection: bit 0 rising, bit 1 falling
  function automatic logic edgeHit(input logic [1:0] es, input logic r, input logic f);
    return (es[0] & r) | (es[1] & f);
  endfunction : edgeHit

endpackage : gpt_pkg

// *** verification/general_purpose_timer_unit_chk.sv ***
// Purpose: Port timing checks for the timer unit
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Checks only what the design drives, with the bus valid and ready inputs as conditions
`timescale 1ns/10ps
module general_purpose_timer_unit_chk
  import gpt_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [5:0]  requestFlags
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after address taken");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while read pending");
  a_rdata_width: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY |->
    s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_flag_clear: assert property (|($past(requestFlags) & ~requestFlags) |->
    $rose(s_axi_bvalid))
    else $error("request flag fell without a write");
endmodule : general_purpose_timer_unit_chk

bind general_purpose_timer_unit general_purpose_timer_unit_chk i_general_purpose_timer_unit_chk (.*);

// *** verification/gpt_pin_model.sv ***
// Purpose: Sensor, gate and capture pins facing the timer unit
// Assumes: Requests change right after a rising edge
// Notes:   Gray walk, so one sensor line moves per step
`timescale 1ns/10ps
module gpt_pin_model (
  input  wire logic       sys_clk,
  input  wire logic       qStep,
  input  wire logic       qDown,
  input  wire logic [2:0] lvl,
  output var  logic [2:0] timerInputPin,
  output var  logic [2:0] directionInputPin,
  output var  logic       captureInputPin
);
  logic [1:0] phase = 2'h0;
  always_ff @(posedge sys_clk) begin
    if (qStep) phase <= qDown ? phase - 2'h1 : phase + 2'h1;
  end
  assign timerInputPin     = {lvl[1], ^phase, lvl[0]};
  assign directionInputPin = {1'b0, phase[1], 1'b0};
  assign captureInputPin   = lvl[2];
endmodule : gpt_pin_model

// *** verification/test_general_purpose_timer_unit.sv ***
// Purpose: Self-checking bench for the timer unit
// Assumes: Registers reached over AXI4-Lite, pins from the pin model
// Notes:   Count windows allow for prescaler phase and bus delay
`timescale 1ns/10ps
module test_general_purpose_timer_unit;
  import gpt_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, qStep = 1'b0, qDown = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, lvl = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, dat;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0]  timerInputPin, directionInputPin;
  logic        captureInputPin, toggleOutputPin;
  logic [5:0]  requestFlags;
  int          bad_count = 0, checks_done = 0;

  always #5 sys_clk = ~sys_clk;
  general_purpose_timer_unit i_general_purpose_timer_unit (.*);
  gpt_pin_model i_gpt_pin_model (.*);

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready is raised only after the answer shows, so a stalled answer is seen too
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int         n;
    logic [2:0] p;
    logic [2:0] h;
    n = 0;
    p = {wr, wr, !wr};
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= p;
    while (p != 3'h0 && n < 40) begin
      @(negedge sys_clk);
      h = p & {s_axi_awready, s_axi_wready, s_axi_arready};
      @(posedge sys_clk);
      p = p & ~h;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= p;
      n++;
    end
    do begin
      @(negedge sys_clk);
      n++;
    end while (n < 80 && !(wr ? s_axi_bvalid : s_axi_rvalid));
    @(posedge sys_clk);
    {s_axi_bready, s_axi_rready} <= {wr, !wr};
    @(negedge sys_clk);
    rsp = wr ? s_axi_bresp : s_axi_rresp;
    dat = s_axi_rdata;
    @(posedge sys_clk);
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (n >= 80) begin
      bad_count++;
      test_done();
    end
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(dat, exp);
  endtask : rdchk

  task automatic pulse(input int b);
    lvl[b] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    lvl[b] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic step(input logic dn);
    qStep <= 1'b1;
    qDown <= dn;
    @(posedge sys_clk);
    qStep <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : step

  function automatic logic [15:0] g1(input logic [2:0] m, input logic [2:0] s, input logic oe);
    return {6'h00, oe, 2'b00, 1'b1, m, s};
  endfunction : g1

  task automatic t_regs;
    rdchk(ADDR_VAL_CORE_ONE, 32'h0);
    bus(1'b1, ADDR_VAL_AUX_A, 16'ha5c3);
    rdchk(ADDR_VAL_AUX_A, 32'h0000a5c3);
    bus(1'b0, 8'h38, 16'h0000);
    chk(32'(rsp), 32'(RESP_SLVERR));
    $display("t_regs done");
  endtask : t_regs

  task automatic t_counter;
    bus(1'b1, ADDR_VAL_AUX_A, 16'hfffe);
    bus(1'b1, ADDR_CTRL_AUX_A, g1(MODE_COUNTER, 3'h1, 1'b0));
    pulse(0);
    pulse(0);
    rdchk(ADDR_VAL_AUX_A, 32'h0);
    chk(32'(requestFlags[0]), 32'h1);
    $display("t_counter done");
  endtask : t_counter

  task automatic t_timer;
    bus(1'b1, ADDR_VAL_CORE_ONE, 16'hfffc);
    bus(1'b1, ADDR_CTRL_CORE_ONE, g1(MODE_TIMER, 3'h0, 1'b1));
    repeat (160) @(posedge sys_clk);
    bus(1'b0, ADDR_VAL_CORE_ONE, 16'h0000);
    chk(32'(dat >= 32'h0f && dat <= 32'h12), 32'h1);
    chk(32'(toggleOutputPin), 32'h1);
    chk(32'(requestFlags[1]), 32'h1);
    $display("t_timer done");
  endtask : t_timer

  // Control first, so the value written is not bumped by a stale tick
  task automatic t_quad;
    bus(1'b1, ADDR_CTRL_CORE_ONE, g1(MODE_INCREMENTAL, 3'h3, 1'b0));
    bus(1'b1, ADDR_VAL_CORE_ONE, 16'h0010);
    repeat (4) step(1'b0);
    repeat (2) step(1'b1);
    rdchk(ADDR_VAL_CORE_ONE, 32'h12);
    $display("t_quad done");
  endtask : t_quad

  task automatic t_capture;
    bus(1'b1, ADDR_CTRL_AUX_B, g1(MODE_CAPTURE, 3'h1, 1'b0));
    pulse(1);
    rdchk(ADDR_VAL_AUX_B, 32'h12);
    repeat (40) @(posedge sys_clk);
    rdchk(ADDR_VAL_AUX_B, 32'h12);
    $display("t_capture done");
  endtask : t_capture

  task automatic t_reload;
    bus(1'b1, ADDR_VAL_AUX_A, 16'h1234);
    bus(1'b1, ADDR_CTRL_AUX_A, g1(MODE_RELOAD, 3'h1, 1'b0));
    pulse(0);
    rdchk(ADDR_VAL_CORE_ONE, 32'h00001234);
    rdchk(ADDR_VAL_AUX_A, 32'h00001234);
    $display("t_reload done");
  endtask : t_reload

  task automatic t_group_two;
    bus(1'b1, ADDR_CTRL_CAPTURE, 16'h0031);
    bus(1'b1, ADDR_CTRL_AUX_C, 16'h0040);
    repeat (100) @(posedge sys_clk);
    pulse(2);
    bus(1'b0, ADDR_VAL_CAPTURE, 16'h0000);
    chk(32'(dat >= 32'h17 && dat <= 32'h1e), 32'h1);
    bus(1'b0, ADDR_VAL_AUX_C, 16'h0000);
    chk(32'(dat < 32'h6), 32'h1);
    chk(32'(requestFlags[5]), 32'h1);
    bus(1'b1, ADDR_STATUS, 16'h003f);
    chk(32'(requestFlags), 32'h0);
    $display("t_group_two done");
  endtask : t_group_two

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_regs();
    t_counter();
    t_timer();
    t_quad();
    t_capture();
    t_reload();
    t_group_two();
    test_done();
  end
endmodule : test_general_purpose_timer_unit
